// ===== src/crcg_top.sv
// Purpose: Programmable CRC generator with input FIFO, AHB-Lite slave
// Assumes: Single clock hclk; sleep and idle levels synchronous
// Notes: Zero wait state slave, response always OKAY
//
// Chosen here: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "crcg_cfg.svh"


// Summary of operation
// - Taps 1..15 and length set by software
// - Constant term always, x^16 implicit at full
// - FIFO depth 8 if length>7, else 16
// - Count increments when MSb lane written
// - Shift while go and count nonzero
// - One bit per clock, length+1 per word
// - Full at depth, empty at zero count
// - Write when full rolls count to zero
// - Event pulse when count goes one to zero
// - Sleep freezes state, resumes later
// - Idle stops only with stop_in_idle set
// - Length field holds length minus one
// - Go clear keeps shifter off
module crcg_top #(
  parameter int FIFO_MAX = `CRCG_FIFO_MAX
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Power save state of the system
  input wire logic sleep_mode,
  input wire logic idle_mode,
  // Word count falling from one to zero
  output logic crc_event
);
  import crcg_pkg::*;

  // The struct and the FIFO image are fixed at sixteen entries, so
  // any other size is refused rather than silently truncated
  if (FIFO_MAX != `CRCG_FIFO_MAX) begin : g_bad_depth
    $error("crcg_top: FIFO_MAX must equal 16");
  end
  if (`CRCG_DEPTH_SHORT != FIFO_MAX) begin : g_bad_short
    $error("crcg_top: short-word depth must fill the FIFO");
  end
  if (2 * `CRCG_DEPTH_LONG != `CRCG_DEPTH_SHORT) begin : g_bad_long
    $error("crcg_top: long-word depth must be half the FIFO");
  end
  if (`CRCG_WORD_W != 16) begin : g_bad_word
    $error("crcg_top: remainder and taps are 16 bits wide");
  end

  // Signals shared by the read mux and the next-state logic
  crcg_state_t s_q;
  crcg_state_t s_d;
  crcg_word_t lfsr_next;
  crcg_word_t result_w;
  logic [1:0] lanes;
  logic [4:0] depth_w;
  logic full_w;
  logic susp;
  logic shift_now;
  logic [31:0] rd_word;

  // Depth follows the length field: long words get half the entries
  assign depth_w = (s_q.poly_len_minus1 > `CRCG_POLY_LEN_MINUS1_SPLIT) ?
                   `CRCG_DEPTH_LONG : `CRCG_DEPTH_SHORT;
  assign full_w = (s_q.cnt == depth_w);

  // Sleep, or Idle with stop_in_idle, freezes the shifter at once;
  // the mode machine only follows one edge later
  assign susp = sleep_mode | (idle_mode & s_q.sidl);

  // One bit per clock while running, awake and with words queued
  assign shift_now = (s_q.mode == CRCG_RUN) && !susp &&
                     (s_q.cnt != 5'h00);

  // Result shows only the low length+1 bits of the remainder
  genvar gb;
  generate
    for (gb = 0; gb < `CRCG_WORD_W; gb = gb + 1) begin : g_result
      assign result_w[gb] = (4'(gb) <= s_q.poly_len_minus1) ?
                            s_q.crc[gb] : 1'b0;
    end
  endgenerate

  // Byte lanes of the low halfword touched by a transfer; the upper
  // halfword carries no state, so a byte aimed at it touches nothing
  always_comb begin
    unique case (hsize)
      3'h0: lanes = (haddr[1:0] == 2'h0) ? 2'h1 :
                    (haddr[1:0] == 2'h1) ? 2'h2 : 2'h0;
      3'h1: lanes = haddr[1] ? 2'h0 : 2'h3;
      default: lanes = 2'h3;
    endcase
  end

  // Next remainder for the bit now at the head of the FIFO; bits
  // leave each word from bit poly_len_minus1 down to bit zero
  crcg_lfsr u_lfsr (
    .crc_in (s_q.crc),
    .taps (s_q.taps),
    .poly_len_minus1 (s_q.poly_len_minus1),
    .din (s_q.mem[s_q.rptr][s_q.idx]),
    .crc_out (lfsr_next)
  );

  // Read data is prepared in the address phase; a read taken in the
  // data phase of a write still sees the state before that write.
  // Register map, one aligned word each:
  //   control: stop_in_idle 13, word count 12:8, full 7, empty 6,
  //            shift_go 4, length minus one 3:0
  //   taps: tap enables 15:1, bit 0 reads zero
  //   data: a write queues a word, a read gives the remainder
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (haddr[7:0])
      `CRCG_OFS_CTRL: begin
        rd_word[`CRCG_BIT_SIDL] = s_q.sidl;
        rd_word[`CRCG_CNT_HI:`CRCG_CNT_LO] = s_q.cnt;
        rd_word[`CRCG_BIT_FULL] = full_w;
        rd_word[`CRCG_BIT_EMPTY] = (s_q.cnt == 5'h00);
        rd_word[`CRCG_BIT_GO] = s_q.go;
        rd_word[`CRCG_POLY_LEN_MINUS1_HI:0] = s_q.poly_len_minus1;
      end
      `CRCG_OFS_TAPS: rd_word[15:1] = s_q.taps[15:1];
      `CRCG_OFS_WDAT: rd_word[15:0] = result_w;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Next state of the whole block; a push and a pop in one cycle
  // leave the count alone, and an overflowing push beats the pop
  always_comb begin
    crcg_word_t merged;
    logic take;
    logic push;
    logic pop;
    merged = s_q.stage;
    take = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    s_d = s_q;
    s_d.irq = 1'b0;
    s_d.rdy = 1'b1;

    // Address phase captured whenever the bus is ready
    take = hready & hsel & htrans[1];
    if (hready) begin
      s_d.ap_wr = take & hwrite;
      s_d.ap_addr = haddr[7:0];
      s_d.ap_lanes = lanes;
    end
    if (take & ~hwrite) begin
      s_d.rdata = rd_word;
    end

    // Shifter mode; Sleep, or Idle with stop_in_idle, holds it
    unique case (s_q.mode)
      CRCG_OFF: begin
        if (s_q.go) begin
          s_d.mode = susp ? CRCG_HOLD : CRCG_RUN;
        end
      end
      CRCG_RUN: begin
        if (!s_q.go) begin
          s_d.mode = CRCG_OFF;
        end else if (susp) begin
          s_d.mode = CRCG_HOLD;
        end
      end
      CRCG_HOLD: begin
        if (!s_q.go) begin
          s_d.mode = CRCG_OFF;
        end else if (!susp) begin
          s_d.mode = CRCG_RUN;
        end
      end
      default: s_d.mode = CRCG_OFF;
    endcase

    // One bit per clock while running with words queued
    if (shift_now) begin
      s_d.crc = lfsr_next;
      if (s_q.idx == 4'h0) begin
        pop = 1'b1;
        s_d.rptr = s_q.rptr + 4'h1;
        s_d.idx = s_q.poly_len_minus1;
      end else begin
        s_d.idx = s_q.idx - 4'h1;
      end
    end else if (s_q.cnt == 5'h00) begin
      s_d.idx = s_q.poly_len_minus1;
    end

    // Data phase of a register write; hwdata is valid only now,
    // one cycle after the address was seen
    if (s_q.ap_wr) begin
      unique case (s_q.ap_addr)
        `CRCG_OFS_CTRL: begin
          if (s_q.ap_lanes[1]) begin
            s_d.sidl = hwdata[`CRCG_BIT_SIDL];
          end
          if (s_q.ap_lanes[0]) begin
            s_d.go = hwdata[`CRCG_BIT_GO];
            s_d.poly_len_minus1 = hwdata[`CRCG_POLY_LEN_MINUS1_HI:0];
          end
        end
        `CRCG_OFS_TAPS: begin
          if (s_q.ap_lanes[1]) begin
            s_d.taps[15:8] = hwdata[15:8];
          end
          if (s_q.ap_lanes[0]) begin
            s_d.taps[7:1] = hwdata[7:1];
          end
        end
        `CRCG_OFS_WDAT: begin
          if (s_q.ap_lanes[0]) begin
            merged[7:0] = hwdata[7:0];
          end
          if (s_q.ap_lanes[1]) begin
            merged[15:8] = hwdata[15:8];
          end
          s_d.stage = merged;
          // A word counts once the lane with its MSb is written
          push = s_q.ap_lanes[s_q.poly_len_minus1[3]];
        end
        default: ;
      endcase
    end

    // Word count, pointers and the falling event
    if (push && full_w) begin
      // Overflow empties the FIFO and stays silent; the entries are not
      // cleared, the pointers simply meet again
      s_d.cnt = 5'h00;
      s_d.wptr = s_d.rptr;
      s_d.idx = s_q.poly_len_minus1;
    end else begin
      if (push) begin
        s_d.mem[s_q.wptr] = merged;
        s_d.wptr = s_q.wptr + 4'h1;
      end
      s_d.cnt = s_q.cnt + {4'h0, push} - {4'h0, pop};
      // Event survives a suspend that starts next cycle
      s_d.irq = pop & ~push & (s_q.cnt == 5'h01);
    end
    // Long-word depth rolls pointers inside the 8 used entries, so a
    // long-word FIFO never reaches the upper half of the array
    if (depth_w == `CRCG_DEPTH_LONG) begin
      s_d.wptr[3] = 1'b0;
      s_d.rptr[3] = 1'b0;
    end
  end

  // State register; reset leaves an empty FIFO and a zero remainder,
  // and hardware never clears the remainder after that
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.rdy <= 1'b1;
      s_q.poly_len_minus1 <= `CRCG_RST_POLY_LEN_MINUS1;
      s_q.taps <= `CRCG_RST_TAPS;
      s_q.crc <= `CRCG_RST_CRC;
      s_q.mode <= CRCG_OFF;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register; the response is fixed
  // at OKAY, so it needs no flop
  assign hrdata = s_q.rdata;
  assign hreadyout = s_q.rdy;
  assign hresp = 1'b0;
  assign crc_event = s_q.irq;

endmodule : crcg_top
`default_nettype wire

// ===== src/crcg_cfg.svh
// Purpose: Constants of the programmable CRC generator
// Assumes: Included by the package and the design modules
// Notes: Offsets are byte addresses on the AHB-Lite register bus
`ifndef CRCG_CFG_SVH
`define CRCG_CFG_SVH

// Register byte offsets
`define CRCG_OFS_CTRL 8'h00
`define CRCG_OFS_TAPS 8'h04
`define CRCG_OFS_WDAT 8'h08

// Control register field positions
`define CRCG_BIT_SIDL 13
`define CRCG_CNT_HI 12
`define CRCG_CNT_LO 8
`define CRCG_BIT_FULL 7
`define CRCG_BIT_EMPTY 6
`define CRCG_BIT_GO 4
`define CRCG_POLY_LEN_MINUS1_HI 3

// Data widths and FIFO sizes
`define CRCG_WORD_W 16
`define CRCG_FIFO_MAX 16
`define CRCG_DEPTH_LONG 5'h08
`define CRCG_DEPTH_SHORT 5'h10
`define CRCG_POLY_LEN_MINUS1_SPLIT 4'h7

// Reset values
`define CRCG_RST_POLY_LEN_MINUS1 4'h0
`define CRCG_RST_TAPS 16'h0000
`define CRCG_RST_CRC 16'h0000

`endif

// ===== src/crcg_pkg.sv
// Purpose: Types of the programmable CRC generator
// Assumes: crcg_cfg.svh supplies widths
// Notes: Whole module state lives in one packed struct
`include "crcg_cfg.svh"

package crcg_pkg;

  typedef logic [`CRCG_WORD_W-1:0] crcg_word_t;

  // Shifter control, one-hot
  typedef enum logic [2:0] {
    CRCG_OFF = 3'b001,
    CRCG_RUN = 3'b010,
    CRCG_HOLD = 3'b100
  } crcg_mode_t;

  // Complete state of the generator
  typedef struct packed {
    logic ap_wr;
    logic [7:0] ap_addr;
    logic [1:0] ap_lanes;
    logic [31:0] rdata;
    logic rdy;
    logic sidl;
    logic go;
    logic [3:0] poly_len_minus1;
    crcg_word_t taps;
    logic [4:0] cnt;
    logic [3:0] wptr;
    logic [3:0] rptr;
    logic [3:0] idx;
    crcg_word_t stage;
    crcg_word_t crc;
    crcg_mode_t mode;
    logic irq;
    logic [`CRCG_FIFO_MAX-1:0][`CRCG_WORD_W-1:0] mem;
  } crcg_state_t;

endpackage : crcg_pkg

// ===== src/crcg_lfsr.sv
// Purpose: One shift step of the programmable CRC shift register
// Assumes: Purely combinational; caller registers the result
// Notes: Bits above the polynomial length are forced to zero
`timescale 1ns/10ps
`default_nettype none
`include "crcg_cfg.svh"

module crcg_lfsr (
  // Current remainder and polynomial
  input wire crcg_pkg::crcg_word_t crc_in,
  input wire crcg_pkg::crcg_word_t taps,
  input wire logic [3:0] poly_len_minus1,
  // Serial data bit
  input wire logic din,
  // Next remainder
  output logic [15:0] crc_out
);
  import crcg_pkg::*;

  logic fb;

  // Top stage of the register meets the data bit; x^n is implicit
  assign fb = din ^ crc_in[poly_len_minus1];

  // Constant term always fed back into stage zero
  assign crc_out[0] = fb;

  // Other stages take their tap only when enabled
  genvar i;
  generate
    for (i = 1; i < `CRCG_WORD_W; i = i + 1) begin : g_stage
      assign crc_out[i] = (4'(i) <= poly_len_minus1) ?
        (crc_in[i-1] ^ (taps[i] & fb)) : 1'b0;
    end
  endgenerate

endmodule : crcg_lfsr
`default_nettype wire

// ===== bench/crcg_top_sva.sv
// Purpose: Bus and event checks on the CRC generator ports
// Assumes: One clock hclk; hready follows hreadyout
// Notes: Register reads are judged in their data phase
`timescale 1ns/10ps
`default_nettype none

module crcg_top_sva (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Power save and event
  input wire logic sleep_mode,
  input wire logic crc_event
);
  logic rd_ctl_q;
  logic rd_tap_q;
  wire logic take_rd = hsel && htrans[1] && hready && !hwrite;

  // Which register the current data phase returns
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ctl_q <= 1'b0;
      rd_tap_q <= 1'b0;
    end else begin
      rd_ctl_q <= take_rd && haddr[7:0] == 8'h00;
      rd_tap_q <= take_rd && haddr[7:0] == 8'h04;
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  resp_okay_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  ready_high_a: assert property (hreadyout == 1'b1)
    else $error("wait state inserted");
  empty_zero_a: assert property (rd_ctl_q |->
    hrdata[6] == (hrdata[12:8] == 5'h00)) else $error("empty flag wrong");
  full_depth_a: assert property (rd_ctl_q |->
    hrdata[7] == (hrdata[12:8] == (hrdata[3:0] > 4'h7 ? 5'h08 : 5'h10)))
    else $error("full flag wrong");
  count_max_a: assert property (rd_ctl_q |->
    hrdata[12:8] <= (hrdata[3:0] > 4'h7 ? 5'h08 : 5'h10)
    && hrdata[31:14] == 18'h0 && !hrdata[5]) else $error("count too big");
  taps_low_a: assert property (rd_tap_q |->
    !hrdata[0] && hrdata[31:16] == 16'h0) else $error("tap bit 0 set");
  event_pulse_a: assert property (crc_event |=> !crc_event)
    else $error("event longer than one cycle");
  sleep_quiet_a: assert property (sleep_mode |=> !crc_event)
    else $error("event while asleep");
endmodule : crcg_top_sva

bind crcg_top crcg_top_sva chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hrdata, .hreadyout, .hresp, .sleep_mode, .crc_event);

`default_nettype wire

// ===== bench/crcg_top_bench.sv
// Purpose: Self-checking bench for the CRC generator
// Assumes: AHB-Lite single transfers, hready from hreadyout
// Notes: Remainder is never cleared, so the model carries it on
`timescale 1ns/10ps
`default_nettype none

module crcg_top_bench;
  import crcg_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic sleep_mode = 1'b0;
  logic idle_mode = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic crc_event;
  logic [31:0] rd_v;
  int num_errors = 0;
  int checks = 0;
  int events = 0;
  crcg_word_t crc_exp = 16'h0;
  crcg_word_t taps = 16'h1020;
  crcg_word_t d;

  // Clock at 125 MHz
  always #4 hclk = ~hclk;

  crcg_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp(),
    .sleep_mode, .idle_mode, .crc_event);

  // Counted on the falling edge, away from the bench's own edge
  always @(negedge hclk) if (crc_event === 1'b1) events++;

  // One single transfer; address held until hready is seen
  task automatic xfer(input logic wr, input logic [7:0] a,
      input logic [2:0] sz, input logic [31:0] v);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= sz;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_v = hrdata;
  endtask : xfer

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 3'h2, 32'h0);
    cmp(rd_v, e);
  endtask : rdc

  // Poll control until the queue is empty
  task automatic drain();
    do xfer(1'b0, 8'h00, 3'h2, 32'h0); while (rd_v[6] !== 1'b1);
  endtask : drain

  // Reference shift register, top bit first
  function automatic crcg_word_t step(crcg_word_t c, int p, crcg_word_t w);
    logic fb;
    for (int i = p; i >= 0; i--) begin
      fb = w[i] ^ c[p];
      c = ((c << 1) ^ ({16{fb}} & taps)) | {15'h0, fb};
    end
    return c & crcg_word_t'((17'h1 << (p + 1)) - 1);
  endfunction : step

  task automatic final_report();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report

  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(8'h00, 32'h40);
    rdc(8'h04, 32'h0);
    $display("test reset done");
    // Sixteen-bit polynomial; go held off while queuing
    xfer(1'b1, 8'h00, 3'h2, 32'hf);
    xfer(1'b1, 8'h04, 3'h2, {16'h0, taps});
    rdc(8'h04, {16'h0, taps});
    for (int w = 1; w < 4; w++) begin
      d = 16'h1234 * 16'(w);
      xfer(1'b1, 8'h08, 3'h2, {16'h0, d});
      crc_exp = step(crc_exp, 15, d);
    end
    rdc(8'h00, 32'h30f);
    xfer(1'b1, 8'h00, 3'h2, 32'h1f);
    drain();
    rdc(8'h00, 32'h5f);
    cmp(events, 1);
    rdc(8'h08, {16'h0, crc_exp});
    $display("test shift done");
    // Frozen in sleep, in idle with stop set; running in plain idle
    for (int m = 0; m < 3; m++) begin
      sleep_mode <= (m == 0);
      idle_mode <= (m != 0);
      xfer(1'b1, 8'h00, 3'h2, m == 2 ? 32'h1f : 32'h201f);
      xfer(1'b1, 8'h08, 3'h2, 32'hbeef);
      crc_exp = step(crc_exp, 15, 16'hbeef);
      repeat (40) @(posedge hclk);
      rdc(8'h00, m == 2 ? 32'h5f : 32'h211f);
      sleep_mode <= 1'b0;
      idle_mode <= 1'b0;
      drain();
    end
    rdc(8'h08, {16'h0, crc_exp});
    $display("test power save done");
    // Fill to depth, then one more write rolls the count over
    for (int k = 0; k < 2; k++) begin
      xfer(1'b1, 8'h00, 3'h2, 32'h7 + k);
      for (int w = 0; w < 16 - 8 * k; w++)
        xfer(1'b1, 8'h08, 3'(2 * k), 32'h5a);
      rdc(8'h00, {19'h0, 5'(16 - 8 * k), 8'(8'h87 + k)});
      xfer(1'b1, 8'h08, 3'h2, 32'h5a);
      rdc(8'h00, 32'h47 + k);
    end
    cmp(events, 4);
    $display("test full done");
    // Continuous feed: prime, start, then top up while below eight words
    xfer(1'b1, 8'h00, 3'h2, 32'hf);
    for (int w = 0; w < 2; w++) begin
      d = 16'h0f0f + 16'(w);
      xfer(1'b1, 8'h08, 3'h2, {16'h0, d});
      crc_exp = step(crc_exp, 15, d);
    end
    xfer(1'b1, 8'h00, 3'h2, 32'h1f);
    for (int w = 2; w < 12; w++) begin
      xfer(1'b0, 8'h00, 3'h2, 32'h0);
      if (rd_v[12:8] < 5'h08) begin
        d = 16'h0f0f + 16'(w);
        xfer(1'b1, 8'h08, 3'h2, {16'h0, d});
        crc_exp = step(crc_exp, 15, d);
      end
    end
    drain();
    cmp(events, 5);
    rdc(8'h08, {16'h0, crc_exp});
    $display("test feed done");
    final_report();
  end

  // Runaway guard, far beyond the several hundred cycles expected
  initial begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    final_report();
  end
endmodule : crcg_top_bench

`default_nettype wire
